// ---- core/wd_pkg.sv ----
// Package: register map, field layout, codes and timing of the link watchdog
package wd_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_CTRL     = 8'h00;
    localparam logic [7:0] OFF_MON_TIME = 8'h04;
    localparam logic [7:0] OFF_STATUS   = 8'h08;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h0C;
    localparam logic [7:0] OFF_IRQ_CLR  = 8'h10;
    localparam logic [7:0] OFF_IRQ_EN   = 8'h14;
    localparam logic [7:0] OFF_RUN_CTRL = 8'h18;

    // Control fields
    localparam int CTRL_SERIAL_BIT = 0;
    localparam int CTRL_ACT_LSB    = 1;
    localparam int RUN_START_BIT   = 0;
    localparam int RUN_STOP_BIT    = 1;

    // Fault action codes
    localparam logic [1:0] ACT_OFF  = 2'h0;
    localparam logic [1:0] ACT_RUN  = 2'h1;
    localparam logic [1:0] ACT_HALT = 2'h2;

    // Status fields
    localparam int STAT_ALARM_BIT   = 0;
    localparam int STAT_RUNNING_BIT = 1;
    localparam int STAT_ACTIVE_BIT  = 2;
    localparam int STAT_SILENCE_LSB = 16;

    // Interrupt event bits
    localparam int IRQ_W         = 4;
    localparam int IRQ_RAISE_BIT = 0;
    localparam int IRQ_CLEAR_BIT = 1;
    localparam int IRQ_HALT_BIT  = 2;
    localparam int IRQ_NAK_BIT   = 3;

    // Monitoring time in seconds
    localparam int         MON_W         = 10;
    localparam logic [9:0] MON_MIN_S     = 10'h01E;
    localparam logic [9:0] MON_MAX_S     = 10'h258;
    localparam logic [9:0] MON_DEFAULT_S = 10'h01E;

    // Negative reply exception codes
    localparam logic [3:0] EXC_MALFORMED  = 4'h1;
    localparam logic [3:0] EXC_PROHIBITED = 4'h2;
    localparam logic [3:0] EXC_BUSY       = 4'h3;

    // One-second time base
    localparam int CLK_PERIOD_NS  = 8;
    localparam int TICK_PERIOD_NS = 1000000000;
    localparam int CYCLES_PER_SEC = TICK_PERIOD_NS / CLK_PERIOD_NS;
endpackage : wd_pkg

// ---- core/sec_tick.sv ----
// One-second tick generator, restartable
`timescale 1ns/1ps
`default_nettype none
module sec_tick import wd_pkg::*; #(
    parameter int unsigned SEC_CYCLES = CYCLES_PER_SEC
) (
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic run,
    input  wire logic restart,
    output logic      tick
);
    localparam int CW = $clog2(SEC_CYCLES);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic          tick;
    } tick_st_t;

    tick_st_t s;
    tick_st_t next_s;

    // Prescaler restarts on a message so each second is whole
    always_comb begin
        next_s      = s;
        next_s.tick = 1'b0;
        if (!run || restart) begin
            next_s.cnt = '0;
        end else if (s.cnt == CW'(SEC_CYCLES - 1)) begin
            next_s.cnt  = '0;
            next_s.tick = 1'b1;
        end else begin
            next_s.cnt = s.cnt + CW'(1);
        end
    end

    // State register
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign tick = s.tick;
endmodule : sec_tick
`default_nettype wire

// ---- core/reply_gen.sv ----
// Reply builder: acknowledge or negative reply with exception code
`timescale 1ns/1ps
`default_nettype none
module reply_gen import wd_pkg::*; (
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       msg_valid,
    input  wire logic       msg_ok,
    input  wire logic       msg_is_write,
    input  wire logic       msg_write_prohibited,
    input  wire logic       msg_state_block,
    output logic            resp_valid,
    output logic            resp_nak,
    output logic [3:0]      resp_code
);
    typedef struct packed {
        logic       valid;
        logic       nak;
        logic [3:0] code;
    } reply_st_t;

    reply_st_t s;
    reply_st_t next_s;

    // Exception code, zero means plain acknowledge
    function automatic logic [3:0] exc_code(input logic ok, input logic wr,
                                            input logic prohib,
                                            input logic blocked);
        if (!ok) begin
            exc_code = EXC_MALFORMED;
        end else if (blocked) begin
            exc_code = EXC_BUSY;
        end else if (wr && prohib) begin
            exc_code = EXC_PROHIBITED;
        end else begin
            exc_code = 4'h0;
        end
    endfunction : exc_code

    // malformed or blocked gets negative reply
    always_comb begin
        next_s       = '0;
        if (msg_valid) begin
            next_s.valid = 1'b1;
            next_s.code  = exc_code(msg_ok, msg_is_write,
                                    msg_write_prohibited, msg_state_block);
            next_s.nak   = (next_s.code != 4'h0);
        end
    end

    // State register
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign resp_valid = s.valid;
    assign resp_nak   = s.nak;
    assign resp_code  = s.code;
endmodule : reply_gen
`default_nettype wire

// ---- core/comm_loss_wd.sv ----
// Serial link loss watchdog with APB registers and reply builder
// Notes on behaviour
// - Supervision runs only in serial communication mode.
// - Alarm rises once silence exceeds the monitoring time.
// - Alarm clears by itself when a host message arrives again.
// - Fault action resets to off, supervision disabled.
// - With action off the alarm is never raised.
// - Keep-running action raises alarm, operation state untouched.
// - Halt action stops operation as the alarm rises.
// - Monitoring time accepts only 30 to 600 seconds.
// - Monitoring time counts seconds, resets to 30.
// - With action off, monitoring time is neither written nor read.
// - Prohibited write answered by negative reply, exception code 2.
// - Malformed or blocked request answered by negative reply.
//
// Register access over APB and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module comm_loss_wd import wd_pkg::*; #(
    parameter int unsigned SEC_CYCLES = CYCLES_PER_SEC
) (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        msg_valid,
    input  wire logic        msg_ok,
    input  wire logic        msg_is_write,
    input  wire logic        msg_write_prohibited,
    input  wire logic        msg_state_block,
    output logic             resp_valid,
    output logic             resp_nak,
    output logic [3:0]       resp_code,
    output logic             comm_loss_alarm,
    output logic             op_running,
    output logic             irq
);
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_WATCH = 3'b010,
        ST_ALARM = 3'b100
    } wd_state_t;

    typedef struct packed {
        wd_state_t          fsm;
        logic               serial;
        logic [1:0]         action;
        logic [MON_W-1:0]   mon_time;
        logic [MON_W-1:0]   silence;
        logic               alarm;
        logic               running;
        logic [IRQ_W-1:0]   irq_stat;
        logic [IRQ_W-1:0]   irq_en;
        logic [31:0]        rdata;
        logic               err;
    } wd_st_t;

    localparam wd_st_t RESET_ST = '{
        fsm:      ST_IDLE,
        serial:   1'b0,
        action:   ACT_OFF,
        mon_time: MON_DEFAULT_S,
        silence:  '0,
        alarm:    1'b0,
        running:  1'b0,
        irq_stat: '0,
        irq_en:   '0,
        rdata:    '0,
        err:      1'b0
    };

    wd_st_t           s;
    wd_st_t           next_s;
    logic             active;
    logic             msg_rx;
    logic             tick;
    logic             setup;
    logic             wr;
    logic [IRQ_W-1:0] ev;
    logic [MON_W-1:0] wval;

    // Monitoring time value lies in the accepted window
    function automatic logic mon_ok(input logic [MON_W-1:0] v);
        mon_ok = (v >= MON_MIN_S) && (v <= MON_MAX_S);
    endfunction : mon_ok

    assign active = s.serial && (s.action != ACT_OFF);
    assign msg_rx = msg_valid && msg_ok;
    assign setup  = psel && !penable;
    assign wr     = psel && penable && pwrite;
    assign wval   = pwdata[MON_W-1:0];

    // Seconds base, held in step with the silence count
    sec_tick #(
        .SEC_CYCLES (SEC_CYCLES)
    ) u_tick (
        .clock   (clock),
        .rst     (rst),
        .run     (active),
        .restart (msg_rx),
        .tick    (tick)
    );

    // Reply to every received request
    reply_gen u_reply (
        .clock                (clock),
        .rst                  (rst),
        .msg_valid            (msg_valid),
        .msg_ok               (msg_ok),
        .msg_is_write         (msg_is_write),
        .msg_write_prohibited (msg_write_prohibited),
        .msg_state_block      (msg_state_block),
        .resp_valid           (resp_valid),
        .resp_nak             (resp_nak),
        .resp_code            (resp_code)
    );

    // Register writes, supervision machine, read data and interrupts
    always_comb begin
        next_s = s;
        ev     = '0;
        // Register writes at the access edge
        if (wr) begin
            case (paddr)
                OFF_CTRL: begin
                    next_s.serial = pwdata[CTRL_SERIAL_BIT];
                    if (pwdata[CTRL_ACT_LSB +: 2] != 2'h3) begin
                        next_s.action = pwdata[CTRL_ACT_LSB +: 2];
                    end
                end
                OFF_MON_TIME: begin
                    if (s.action != ACT_OFF && mon_ok(wval)) begin
                        next_s.mon_time = wval;
                    end
                end
                OFF_IRQ_EN: begin
                    next_s.irq_en = pwdata[IRQ_W-1:0];
                end
                OFF_RUN_CTRL: begin
                    // Operation is restarted only by software
                    if (pwdata[RUN_START_BIT]) begin
                        next_s.running = 1'b1;
                    end
                    if (pwdata[RUN_STOP_BIT]) begin
                        next_s.running = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
        // Supervision state machine
        case (s.fsm)
            ST_IDLE: begin
                next_s.silence = '0;
                next_s.alarm   = 1'b0;
                if (active) begin
                    next_s.fsm = ST_WATCH;
                end
            end
            ST_WATCH: begin
                if (!active) begin
                    next_s.fsm     = ST_IDLE;
                    next_s.silence = '0;
                end else if (msg_rx) begin
                    next_s.silence = '0;
                end else if (s.silence > s.mon_time) begin
                    next_s.fsm             = ST_ALARM;
                    next_s.alarm           = 1'b1;
                    ev[IRQ_RAISE_BIT]      = 1'b1;
                    if (s.action == ACT_HALT) begin
                        next_s.running     = 1'b0;
                        ev[IRQ_HALT_BIT]   = 1'b1;
                    end
                end else if (tick && s.silence != {MON_W{1'b1}}) begin
                    next_s.silence = s.silence + MON_W'(1);
                end
            end
            ST_ALARM: begin
                if (!active) begin
                    next_s.fsm     = ST_IDLE;
                    next_s.alarm   = 1'b0;
                    next_s.silence = '0;
                end else if (msg_rx) begin
                    next_s.fsm        = ST_WATCH;
                    next_s.alarm      = 1'b0;
                    next_s.silence    = '0;
                    ev[IRQ_CLEAR_BIT] = 1'b1;
                end
            end
            default: begin
                next_s.fsm   = ST_IDLE;
                next_s.alarm = 1'b0;
            end
        endcase
        ev[IRQ_NAK_BIT] = resp_valid && resp_nak;
        // Sticky status: a new event wins over a clear
        next_s.irq_stat = s.irq_stat;
        if (wr && paddr == OFF_IRQ_CLR) begin
            next_s.irq_stat = s.irq_stat & ~pwdata[IRQ_W-1:0];
        end
        next_s.irq_stat = next_s.irq_stat | ev;
        // Read data and error prepared in the setup cycle
        next_s.rdata = '0;
        next_s.err   = 1'b0;
        if (setup) begin
            case (paddr)
                OFF_CTRL: begin
                    next_s.rdata[CTRL_SERIAL_BIT]     = s.serial;
                    next_s.rdata[CTRL_ACT_LSB +: 2]   = s.action;
                    next_s.err = pwrite && (pwdata[CTRL_ACT_LSB +: 2] == 2'h3);
                end
                OFF_MON_TIME: begin
                    if (s.action == ACT_OFF) begin
                        next_s.err = 1'b1;
                    end else if (pwrite) begin
                        next_s.err = !mon_ok(wval);
                    end else begin
                        next_s.rdata[MON_W-1:0] = s.mon_time;
                    end
                end
                OFF_STATUS: begin
                    next_s.rdata[STAT_ALARM_BIT]   = s.alarm;
                    next_s.rdata[STAT_RUNNING_BIT] = s.running;
                    next_s.rdata[STAT_ACTIVE_BIT]  = active;
                    next_s.rdata[STAT_SILENCE_LSB +: MON_W] = s.silence;
                    next_s.err = pwrite;
                end
                OFF_IRQ_STAT: begin
                    next_s.rdata[IRQ_W-1:0] = s.irq_stat;
                    next_s.err = pwrite;
                end
                OFF_IRQ_CLR: begin
                    next_s.err = !pwrite;
                end
                OFF_IRQ_EN: begin
                    next_s.rdata[IRQ_W-1:0] = s.irq_en;
                end
                OFF_RUN_CTRL: begin
                    next_s.rdata[RUN_START_BIT] = s.running;
                end
                default: begin
                    next_s.err = 1'b1;
                end
            endcase
        end else if (psel) begin
            next_s.rdata = s.rdata;
            next_s.err   = s.err;
        end
    end

    // State register
    // action off after reset
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s <= RESET_ST;
        end else begin
            s <= next_s;
        end
    end

    // Outputs
    assign pready          = 1'b1;
    assign prdata          = s.rdata;
    assign pslverr         = s.err && psel && penable;
    assign comm_loss_alarm = s.alarm;
    assign op_running      = s.running;
    assign irq             = |(s.irq_stat & s.irq_en);

    // Checks on the supervision behaviour
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    a_serial_only_alarm: assert property (
        !s.serial |=> !comm_loss_alarm)
        else $error("alarm outside serial mode");

    a_alarm_on_timeout: assert property (
        s.fsm == ST_WATCH && active && !msg_rx && !wr
        && s.silence > s.mon_time
        |=> comm_loss_alarm && s.irq_stat[IRQ_RAISE_BIT])
        else $error("no alarm after silence beyond limit");

    a_alarm_self_clear: assert property (
        comm_loss_alarm && msg_rx |=> !comm_loss_alarm)
        else $error("alarm kept after host message");

    a_off_never_alarm: assert property (
        s.action == ACT_OFF |=> !comm_loss_alarm [*2])
        else $error("alarm with action off");

    a_run_keeps_state: assert property (
        $rose(comm_loss_alarm) && $past(s.action) == ACT_RUN
        && !$past(wr) |-> op_running == $past(op_running))
        else $error("keep-running action changed operation");

    a_halt_stops_op: assert property (
        $rose(comm_loss_alarm) && $past(s.action) == ACT_HALT
        |-> !op_running)
        else $error("halt action left operation running");

    a_mon_in_range: assert property (
        s.mon_time >= MON_MIN_S && s.mon_time <= MON_MAX_S)
        else $error("monitoring time out of range");

    a_mon_unavailable: assert property (
        setup && paddr == OFF_MON_TIME && s.action == ACT_OFF
        |=> pslverr && prdata == 32'h0000_0000)
        else $error("monitoring time reachable with action off");

    a_nak_prohibited: assert property (
        msg_valid && msg_ok && msg_is_write && msg_write_prohibited
        && !msg_state_block
        |=> resp_valid && resp_nak && resp_code == EXC_PROHIBITED)
        else $error("prohibited write not refused with code 2");

    a_nak_malformed: assert property (
        msg_valid && (!msg_ok || msg_state_block) |=> resp_valid && resp_nak)
        else $error("bad or blocked request not refused");

    a_silence_restart: assert property (
        (msg_rx || !active) |=> s.silence == '0)
        else $error("silence count not restarted");

    // Scenario coverage
    c_alarm_raised: cover property ($rose(comm_loss_alarm));
    c_alarm_cleared: cover property (comm_loss_alarm ##1 !comm_loss_alarm);
    c_halt_stop: cover property ($fell(op_running) && comm_loss_alarm);
    c_nak_code2: cover property (resp_nak && resp_code == EXC_PROHIBITED);
endmodule : comm_loss_wd
`default_nettype wire

// ---- bench/host_model.sv ----
// Host side model: one-cycle requests, scrambled idle qualifiers
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input  wire logic clock,
    output logic      msg_valid,
    output logic      msg_ok,
    output logic      msg_is_write,
    output logic      msg_write_prohibited,
    output logic      msg_state_block
);
    // Quiet link at start
    initial begin
        msg_valid = 1'b0;
        {msg_ok, msg_is_write, msg_write_prohibited, msg_state_block} = 4'h5;
    end

    // One request, q = {ok, write, prohibited, blocked}
    task automatic send(input logic [3:0] q);
        msg_valid <= 1'b1;
        {msg_ok, msg_is_write, msg_write_prohibited, msg_state_block} <= q;
        @(posedge clock);
        // Qualifiers mean nothing now, so show the inverse
        msg_valid <= 1'b0;
        {msg_ok, msg_is_write, msg_write_prohibited, msg_state_block} <= ~q;
    endtask : send
endmodule : host_model
`default_nettype wire

// ---- bench/tb_serial_comm_loss_watchdog.sv ----
// Self-checking bench of the link loss watchdog
`timescale 1ns/1ps
`default_nettype none
module tb_serial_comm_loss_watchdog import wd_pkg::*; ;
    localparam int SEC = 4;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, resp_valid, resp_nak, alarm, op_running;
    logic        irq, msg_valid, msg_ok, msg_is_write, msg_wp, msg_sb;
    logic [3:0]  resp_code;
    int          n_mismatch = 0, compares = 0, n, mon = 30;

    always #4 clock = ~clock;

    comm_loss_wd #(.SEC_CYCLES(SEC)) i_dut (
        .clock(clock), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .msg_valid(msg_valid),
        .msg_ok(msg_ok), .msg_is_write(msg_is_write),
        .msg_write_prohibited(msg_wp), .msg_state_block(msg_sb),
        .resp_valid(resp_valid), .resp_nak(resp_nak),
        .resp_code(resp_code), .comm_loss_alarm(alarm),
        .op_running(op_running), .irq(irq));

    host_model i_host (
        .clock(clock), .msg_valid(msg_valid), .msg_ok(msg_ok),
        .msg_is_write(msg_is_write), .msg_write_prohibited(msg_wp),
        .msg_state_block(msg_sb));

    // Verdict and end of run
    task automatic summarize();
        $display("mismatches %0d, compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : summarize

    // Compare seen against expected
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask : check

    // Expected reply {nak, code} from the code priority order
    function automatic logic [4:0] exp_reply(input logic [3:0] q);
        logic [3:0] c;
        c = !q[3] ? EXC_MALFORMED : q[0] ? EXC_BUSY :
            (q[2] && q[1]) ? EXC_PROHIBITED : 4'h0;
        exp_reply = {c != 4'h0, c};
    endfunction : exp_reply

    // Reply model: one expected reply queued per request
    logic [4:0] exp_q[$];
    always @(posedge clock) begin
        if (resp_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                check(resp_valid, 1'b0);
            end else begin
                check({resp_nak, resp_code}, exp_q.pop_front());
            end
        end
        if (msg_valid === 1'b1) begin
            exp_q.push_back(exp_reply({msg_ok, msg_is_write, msg_wp, msg_sb}));
        end
    end

    // One APB transfer, error flag compared at the pready edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic err);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clock);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) begin
            n_mismatch++;
            summarize();
        end
        rd = prdata;
        check(pslverr, err);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask : apb

    task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                       input logic err);
        apb(1'b0, a, 32'h0, err);
        check(rd, e);
    endtask : rdc

    // Request and its reply, expected code from priority order
    task automatic msg(input logic [3:0] q);
        i_host.send(q);
        @(posedge clock);
        check({resp_valid, resp_nak, resp_code}, {1'b1, exp_reply(q)});
    endtask : msg

    // Bounded wait for an alarm level, n counts cycles
    task automatic wait_alarm(input logic lvl, input int lim);
        n = 0;
        while (alarm !== lvl && n < lim) begin
            @(posedge clock);
            n++;
        end
        if (n >= lim) begin
            n_mismatch++;
            summarize();
        end
    endtask : wait_alarm

    initial begin
        void'($urandom(49));
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        rdc(OFF_CTRL, 32'h0, 1'b0);
        rdc(OFF_MON_TIME, 32'h0, 1'b1);
        apb(1'b1, OFF_MON_TIME, 32'd100, 1'b1);
        apb(1'b0, 8'h40, 32'h0, 1'b1);
        check(irq, 1'b0);
        // Random request kinds, then a prohibited write
        repeat (12) msg(4'($urandom));
        msg(4'b1110);
        rdc(OFF_IRQ_STAT, 32'h8, 1'b0);
        apb(1'b1, OFF_IRQ_CLR, 32'hF, 1'b0);
        rdc(OFF_IRQ_STAT, 32'h0, 1'b0);
        // Serial mode, keep running, reserved action refused
        apb(1'b1, OFF_CTRL, 32'h3, 1'b0);
        apb(1'b1, OFF_CTRL, 32'h7, 1'b1);
        rdc(OFF_CTRL, 32'h3, 1'b0);
        rdc(OFF_MON_TIME, 32'h1E, 1'b0);
        // Monitoring time limits
        apb(1'b1, OFF_MON_TIME, 32'd29, 1'b1);
        apb(1'b1, OFF_MON_TIME, 32'd601, 1'b1);
        apb(1'b1, OFF_MON_TIME, 32'd600, 1'b0);
        rdc(OFF_MON_TIME, 32'd600, 1'b0);
        rdc(OFF_MON_TIME - 8'h4, 32'h3, 1'b0);
        apb(1'b1, OFF_MON_TIME, mon, 1'b0);
        rdc(OFF_MON_TIME, mon, 1'b0);
        apb(1'b1, OFF_RUN_CTRL, 32'h1, 1'b0);
        apb(1'b1, OFF_IRQ_EN, 32'h1, 1'b0);
        // Silence beyond the monitoring time
        msg(4'b1000);
        wait_alarm(1'b1, 40 * SEC);
        check(n > mon * SEC + 4 && n <= (mon + 1) * SEC + 4, 1);
        check(op_running, 1'b1);
        apb(1'b0, OFF_STATUS, 32'h0, 1'b0);
        check(rd[2:0], 3'h7);
        check(irq, 1'b1);
        apb(1'b1, OFF_IRQ_EN, 32'h0, 1'b0);
        check(irq, 1'b0);
        apb(1'b1, OFF_IRQ_EN, 32'h1, 1'b0);
        apb(1'b1, OFF_IRQ_CLR, 32'h1, 1'b0);
        check(irq, 1'b0);
        msg(4'b1000);
        check(alarm, 1'b0);
        rdc(OFF_IRQ_STAT, 32'h2, 1'b0);
        // Halt action, timer restarted by a mid-count request
        apb(1'b1, OFF_CTRL, 32'h5, 1'b0);
        repeat (20 * SEC) @(posedge clock);
        msg(4'b1000);
        wait_alarm(1'b1, 40 * SEC);
        check(n > mon * SEC + 4 && n <= (mon + 1) * SEC + 4, 1);
        check(op_running, 1'b0);
        rdc(OFF_IRQ_STAT, 32'h7, 1'b0);
        msg(4'b1000);
        check({alarm, op_running}, 2'b00);
        apb(1'b1, OFF_RUN_CTRL, 32'h1, 1'b0);
        check(op_running, 1'b1);
        // Action off and non-serial mode stay silent
        apb(1'b1, OFF_CTRL, 32'h1, 1'b0);
        rdc(OFF_MON_TIME, 32'h0, 1'b1);
        repeat (35 * SEC) @(posedge clock);
        check(alarm, 1'b0);
        apb(1'b1, OFF_CTRL, 32'h2, 1'b0);
        repeat (35 * SEC) @(posedge clock);
        check(alarm, 1'b0);
        apb(1'b0, OFF_STATUS, 32'h0, 1'b0);
        check(rd[2], 1'b0);
        // Read-only, write-only and stop-wins decoding
        apb(1'b1, OFF_STATUS, 32'h0, 1'b1);
        rdc(OFF_IRQ_CLR, 32'h0, 1'b1);
        apb(1'b1, OFF_RUN_CTRL, 32'h3, 1'b0);
        rdc(OFF_RUN_CTRL, 32'h0, 1'b0);
        check(exp_q.size(), 0);
        summarize();
    end
endmodule : tb_serial_comm_loss_watchdog
`default_nettype wire
